// ===== brf_defs.vh
// Constants for the bridge read/write forwarding block
// Included by brf_forward.v; definitions only
`ifndef BRF_DEFS_VH
`define BRF_DEFS_VH
// APB register offsets
`define BRF_OFF_CTRL 8'h00
`define BRF_OFF_PFBASE 8'h04
`define BRF_OFF_PFLIM 8'h08
`define BRF_OFF_RLIM 8'h0C
`define BRF_OFF_MTO 8'h10
`define BRF_OFF_STAT 8'h14
// Control fields
`define BRF_CTRL_FB2B_UP 0
`define BRF_CTRL_FB2B_DN 1
`define BRF_CTRL_SERR_EN 2
`define BRF_CTRL_FLOW 3
`define BRF_CTRL_CLS_LSB 8
`define BRF_CTRL_CLS_MSB 15
// Status fields
`define BRF_STAT_RETRY 0
`define BRF_STAT_MTO 1
`define BRF_STAT_PW_LSB 8
`define BRF_STAT_PW_MSB 12
`define BRF_STAT_DW_LSB 16
`define BRF_STAT_DW_MSB 18
// Reset values
`define BRF_CTRL_RST 32'h0000_0000
`define BRF_PFBASE_RST 32'hFFFF_FFFF
`define BRF_PFLIM_RST 32'h0000_0000
`define BRF_RLIM_RST 32'h0100_0000
`define BRF_MTO_RST 32'h0000_8000
// Bus commands
`define BRF_CMD_IOR 4'h2
`define BRF_CMD_MR 4'h6
`define BRF_CMD_CFGR 4'hA
`define BRF_CMD_MRM 4'hC
`define BRF_CMD_MRL 4'hE
// Depths in DWORDs or queue entries, boundaries in DWORDs
`define BRF_PW_DEPTH 5'h10
`define BRF_DQ_DEPTH 3'h4
`define BRF_RDB_DEPTH 6'h20
`define BRF_LINE_DEF 11'h010
`define BRF_PAGE_DW 11'h400
// Engine states
`define BRF_S_IDLE 2'h0
`define BRF_S_ISSUE 2'h1
`define BRF_S_HOLD 2'h2
`endif

// ===== brf_forward.v
// Read/write forwarding engine of a two-port bus bridge, APB registers.
// Bus-side strobes come from same-clock protocol logic; no synchronisers.
// Behaviour
// - accept posted write while one DWORD free
// - disconnect initiator when posted buffer fills
// - accept delayed write while queue entry free
// - fast back-to-back second write retried when full
// - every read is delayed, classified prefetchable or not
// - prefetch speculatively, all byte lanes enabled
// - line/multiple prefetch; plain read upstream or by space
// - non-prefetchable: one DWORD, own byte enables
// - I/O, config, non-pref memory never prefetched
// - stop at boundary, disconnect, discard leftover
// - flow-through prefetches to 4KB boundary
// - read/line stop at line or 16 DWORDs
// - multiple: read buffer full or second line
// - capture request, enqueue, answer retry
// - start read after posted writes drained
// - reuse captured address, command, byte enables
// - reissue on retry; no refetch after data
// - failed attempt limit raises system error
// - returned data into opposite read buffer
// - one DWORD per clock up to boundary
// - master timeout discards completed read
// - four reads per direction, no duplicates
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "brf_defs.vh"
module brf_forward #(
  parameter [31:0] RETRY_LIMIT = `BRF_RLIM_RST,
  parameter [31:0] MASTER_TIMEOUT = `BRF_MTO_RST
) (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  // Initiator side writes
  input wire I_PW_BEAT,
  output wire I_PW_TAKE,
  output wire I_PW_DISC,
  input wire I_WR_START,
  input wire I_WR_FB2B,
  output wire I_WR_RETRY,
  input wire I_DW_REQ,
  output wire I_DW_ACK,
  output wire I_DW_RETRY,
  // Target side write drain
  input wire T_PW_DRAIN,
  input wire T_DW_DONE,
  output wire T_FB2B_UP_EN,
  output wire T_FB2B_DN_EN,
  // Initiator side reads
  input wire I_RD_START,
  input wire I_RD_UP,
  input wire [3:0] I_RD_CMD,
  input wire [31:0] I_RD_ADDR,
  input wire I_RD_PAR,
  input wire I_RD_IRDY,
  input wire [3:0] I_RD_BE_N,
  input wire I_RD_END,
  output reg I_RD_RETRY,
  output reg I_RD_VALID,
  output reg [31:0] I_RD_DATA,
  output reg I_RD_DISC,
  // Target side reads
  output wire T_REQ,
  output reg T_UP,
  output reg [3:0] T_CMD,
  output reg [31:0] T_ADDR,
  output reg T_PAR,
  output reg [3:0] T_BE_N,
  output reg [10:0] T_LEN,
  output wire T_LAST,
  input wire T_DVALID,
  input wire [31:0] T_DATA,
  input wire T_RETRY,
  input wire T_END,
  input wire T_ABORT,
  // System error
  output reg PRIMARY_SYSTEM_ERROR_OUT_N
);
  reg [31:0] ctrl_ff, pfbase_ff, pflim_ff, rlim_ff, mto_ff;
  reg st_retry_ff, st_mto_ff;
  reg [4:0] pw_cnt_ff;
  reg [2:0] dw_cnt_ff;
  // Delayed read queue, index {up, slot}
  reg [31:0] q_addr [0:7];
  reg [3:0] q_cmd [0:7];
  reg [3:0] q_be [0:7];
  reg q_par [0:7];
  reg q_pf [0:7];
  reg [1:0] q_rd_ff [0:1];
  reg [1:0] q_wr_ff [0:1];
  reg [2:0] q_cnt_ff [0:1];
  // Read data buffer
  reg [31:0] read_data_buffer [0:31];
  reg [4:0] rdb_wp_ff, rdb_rp_ff;
  reg [5:0] rdb_cnt_ff;
  // Engine
  reg [1:0] state_ff;
  reg eng_up_ff, sending_ff;
  reg [10:0] fetched_ff;
  reg [31:0] attempt_ff, mto_cnt_ff;
  // Captured initiator request
  reg h_up_ff, h_par_ff;
  reg [3:0] h_cmd_ff;
  reg [31:0] h_addr_ff;
  integer i, j;
  wire [7:0] cache_line_size_setting = ctrl_ff[`BRF_CTRL_CLS_MSB:`BRF_CTRL_CLS_LSB];
  wire flow = ctrl_ff[`BRF_CTRL_FLOW];

  // APB: zero-wait slave
  wire apb_wr = PSEL & PENABLE & PWRITE;
  wire apb_rd = PSEL & PENABLE & ~PWRITE;
  wire hit_reg = (PADDR == `BRF_OFF_CTRL) | (PADDR == `BRF_OFF_PFBASE) |
    (PADDR == `BRF_OFF_PFLIM) | (PADDR == `BRF_OFF_RLIM) |
    (PADDR == `BRF_OFF_MTO) | (PADDR == `BRF_OFF_STAT);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit_reg;
  assign T_FB2B_UP_EN = ctrl_ff[`BRF_CTRL_FB2B_UP];
  assign T_FB2B_DN_EN = ctrl_ff[`BRF_CTRL_FB2B_DN];

  always @* begin
    PRDATA = 32'h0000_0000;
    if (apb_rd) begin
      case (PADDR)
        `BRF_OFF_CTRL: PRDATA = ctrl_ff;
        `BRF_OFF_PFBASE: PRDATA = pfbase_ff;
        `BRF_OFF_PFLIM: PRDATA = pflim_ff;
        `BRF_OFF_RLIM: PRDATA = rlim_ff;
        `BRF_OFF_MTO: PRDATA = mto_ff;
        `BRF_OFF_STAT: begin
          PRDATA[`BRF_STAT_RETRY] = st_retry_ff;
          PRDATA[`BRF_STAT_MTO] = st_mto_ff;
          PRDATA[`BRF_STAT_PW_MSB:`BRF_STAT_PW_LSB] = pw_cnt_ff;
          PRDATA[`BRF_STAT_DW_MSB:`BRF_STAT_DW_LSB] = dw_cnt_ff;
        end
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end

  // Write buffering
  wire pw_full = (pw_cnt_ff == `BRF_PW_DEPTH);
  wire pw_push = I_PW_BEAT & ~pw_full;
  assign I_PW_TAKE = ~pw_full;
  assign I_PW_DISC = pw_push & (pw_cnt_ff == `BRF_PW_DEPTH - 5'h01);
  assign I_WR_RETRY = I_WR_START & I_WR_FB2B & pw_full;
  wire dw_full = (dw_cnt_ff == `BRF_DQ_DEPTH);
  assign I_DW_ACK = I_DW_REQ & ~dw_full;
  assign I_DW_RETRY = I_DW_REQ & dw_full;
  wire pw_pop = T_PW_DRAIN & (pw_cnt_ff != 5'h00);
  wire dw_pop = T_DW_DONE & (dw_cnt_ff != 3'h0);

  // Classification of the captured request
  wire is_mr = (h_cmd_ff == `BRF_CMD_MR);
  wire in_pf = (h_addr_ff >= pfbase_ff) & (h_addr_ff <= pflim_ff);
  wire h_pf = (h_cmd_ff == `BRF_CMD_MRL) | (h_cmd_ff == `BRF_CMD_MRM) |
    (is_mr & (h_up_ff | in_pf));

  // Duplicate search in the request's direction
  reg dup;
  reg [1:0] s;
  always @* begin
    dup = 1'b0;
    s = 2'h0;
    for (i = 0; i < 4; i = i + 1) begin
      s = q_rd_ff[h_up_ff] + i[1:0];
      if ((i[2:0] < q_cnt_ff[h_up_ff]) &&
          (q_addr[{h_up_ff, s}] == h_addr_ff) &&
          (q_cmd[{h_up_ff, s}] == h_cmd_ff))
        dup = 1'b1;
    end
  end

  // Head of the engine's direction
  wire [2:0] head = {eng_up_ff, q_rd_ff[eng_up_ff]};
  wire head_match = (eng_up_ff == h_up_ff) &&
    (q_addr[head] == h_addr_ff) && (q_cmd[head] == h_cmd_ff);
  wire ready_data = (state_ff == `BRF_S_HOLD) ||
    ((state_ff == `BRF_S_ISSUE) && flow && (fetched_ff != 11'h000));
  wire rd_hit = I_RD_IRDY & ~sending_ff & ready_data & head_match;
  wire q_free = (q_cnt_ff[h_up_ff] != `BRF_DQ_DEPTH);
  wire enq = I_RD_IRDY & ~rd_hit & ~dup & q_free;

  // Candidate for the next target read and its boundary
  wire pick_up = (q_cnt_ff[0] == 3'h0);
  wire [2:0] cand = {pick_up, q_rd_ff[pick_up]};
  wire [31:0] c_addr = q_addr[cand];
  wire cls_small = (cache_line_size_setting == 8'h01) | (cache_line_size_setting == 8'h02) | (cache_line_size_setting == 8'h04) |
    (cache_line_size_setting == 8'h08);
  wire [10:0] line = cls_small ? {3'h0, cache_line_size_setting} : `BRF_LINE_DEF;
  wire [10:0] off = c_addr[12:2] & (line - 11'h001);
  reg [10:0] c_len;
  always @* begin
    if (!q_pf[cand])
      c_len = 11'h001;
    else if (flow)
      c_len = `BRF_PAGE_DW - {1'b0, c_addr[11:2]};
    else if (q_cmd[cand] == `BRF_CMD_MRM)
      c_len = cls_small ? (line + line - off) : {5'h00, `BRF_RDB_DEPTH};
    else
      c_len = line - off;
  end

  // Target side handshake
  wire rdb_full = (rdb_cnt_ff == `BRF_RDB_DEPTH);
  assign T_REQ = (state_ff == `BRF_S_ISSUE);
  assign T_LAST = T_REQ & ((fetched_ff + 11'h001 == T_LEN) ||
    (rdb_cnt_ff == `BRF_RDB_DEPTH - 6'h01));
  wire push = T_REQ & T_DVALID & ~rdb_full;
  wire pop = sending_ff & (rdb_cnt_ff != 6'h00);
  wire last_out = pop & (rdb_cnt_ff == 6'h01) & ~push;

  // Engine termination events
  wire retry_fail = T_REQ & T_RETRY & (fetched_ff == 11'h000) &
    (attempt_ff + 32'h1 >= rlim_ff);
  wire mto_fail = (state_ff == `BRF_S_HOLD) & ~sending_ff &
    (mto_cnt_ff + 32'h1 >= mto_ff);
  wire drop = retry_fail | mto_fail |
    (T_REQ & T_ABORT) |
    (T_REQ & T_END & (fetched_ff == 11'h000)) |
    ((state_ff == `BRF_S_HOLD) & sending_ff & (last_out | I_RD_END));

  reg [1:0] nxt_state;
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `BRF_S_IDLE:
        if ((pw_cnt_ff == 5'h00) &&
            ((q_cnt_ff[0] != 3'h0) || (q_cnt_ff[1] != 3'h0)))
          nxt_state = `BRF_S_ISSUE;
      `BRF_S_ISSUE:
        if (drop)
          nxt_state = `BRF_S_IDLE;
        else if ((T_END | T_RETRY) & (fetched_ff != 11'h000))
          nxt_state = `BRF_S_HOLD;
        else if (push & T_LAST)
          nxt_state = `BRF_S_HOLD;
      `BRF_S_HOLD:
        if (drop)
          nxt_state = `BRF_S_IDLE;
      default: nxt_state = `BRF_S_IDLE;
    endcase
  end

  // Registers, counters and sticky status
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_ff <= `BRF_CTRL_RST;
      pfbase_ff <= `BRF_PFBASE_RST;
      pflim_ff <= `BRF_PFLIM_RST;
      rlim_ff <= RETRY_LIMIT;
      mto_ff <= MASTER_TIMEOUT;
      st_retry_ff <= 1'b0;
      st_mto_ff <= 1'b0;
      pw_cnt_ff <= 5'h00;
      dw_cnt_ff <= 3'h0;
      PRIMARY_SYSTEM_ERROR_OUT_N <= 1'b1;
    end else begin
      if (apb_wr && PADDR == `BRF_OFF_CTRL)
        ctrl_ff <= PWDATA;
      if (apb_wr && PADDR == `BRF_OFF_PFBASE)
        pfbase_ff <= PWDATA;
      if (apb_wr && PADDR == `BRF_OFF_PFLIM)
        pflim_ff <= PWDATA;
      if (apb_wr && PADDR == `BRF_OFF_RLIM)
        rlim_ff <= PWDATA;
      if (apb_wr && PADDR == `BRF_OFF_MTO)
        mto_ff <= PWDATA;
      // Set beats a same-cycle write-one clear
      st_retry_ff <= retry_fail | (st_retry_ff & ~(apb_wr &&
        PADDR == `BRF_OFF_STAT && PWDATA[`BRF_STAT_RETRY]));
      st_mto_ff <= mto_fail | (st_mto_ff & ~(apb_wr &&
        PADDR == `BRF_OFF_STAT && PWDATA[`BRF_STAT_MTO]));
      PRIMARY_SYSTEM_ERROR_OUT_N <= ~(ctrl_ff[`BRF_CTRL_SERR_EN] &
        (st_retry_ff | st_mto_ff));
      pw_cnt_ff <= pw_cnt_ff + {4'h0, pw_push} - {4'h0, pw_pop};
      dw_cnt_ff <= dw_cnt_ff + {2'h0, I_DW_ACK} - {2'h0, dw_pop};
    end
  end

  // Request capture and queue
  wire deq = drop;
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      h_up_ff <= 1'b0;
      h_par_ff <= 1'b0;
      h_cmd_ff <= 4'h0;
      h_addr_ff <= 32'h0000_0000;
      I_RD_RETRY <= 1'b0;
      for (j = 0; j < 2; j = j + 1) begin
        q_rd_ff[j] <= 2'h0;
        q_wr_ff[j] <= 2'h0;
        q_cnt_ff[j] <= 3'h0;
      end
    end else begin
      if (I_RD_START) begin
        h_up_ff <= I_RD_UP;
        h_cmd_ff <= I_RD_CMD;
        h_addr_ff <= I_RD_ADDR;
        h_par_ff <= I_RD_PAR;
      end
      I_RD_RETRY <= I_RD_IRDY & ~rd_hit;
      if (enq)
        q_wr_ff[h_up_ff] <= q_wr_ff[h_up_ff] + 2'h1;
      if (deq)
        q_rd_ff[eng_up_ff] <= q_rd_ff[eng_up_ff] + 2'h1;
      for (j = 0; j < 2; j = j + 1)
        q_cnt_ff[j] <= q_cnt_ff[j] +
          {2'h0, enq && (h_up_ff == j[0])} -
          {2'h0, deq && (eng_up_ff == j[0])};
    end
  end

  // Queue payload needs no reset; only entries below the count are read
  always @(posedge MCLK) begin
    if (enq) begin
      q_addr[{h_up_ff, q_wr_ff[h_up_ff]}] <= h_addr_ff;
      q_cmd[{h_up_ff, q_wr_ff[h_up_ff]}] <= h_cmd_ff;
      q_par[{h_up_ff, q_wr_ff[h_up_ff]}] <= h_par_ff;
      q_be[{h_up_ff, q_wr_ff[h_up_ff]}] <= I_RD_BE_N;
      q_pf[{h_up_ff, q_wr_ff[h_up_ff]}] <= h_pf;
    end
    if (push)
      read_data_buffer[rdb_wp_ff] <= T_DATA;
  end

  // Target read engine and delivery
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff <= `BRF_S_IDLE;
      eng_up_ff <= 1'b0;
      sending_ff <= 1'b0;
      fetched_ff <= 11'h000;
      attempt_ff <= 32'h0000_0000;
      mto_cnt_ff <= 32'h0000_0000;
      rdb_wp_ff <= 5'h00;
      rdb_rp_ff <= 5'h00;
      rdb_cnt_ff <= 6'h00;
      T_UP <= 1'b0;
      T_CMD <= 4'h0;
      T_ADDR <= 32'h0000_0000;
      T_PAR <= 1'b0;
      T_BE_N <= 4'h0;
      T_LEN <= 11'h000;
      I_RD_VALID <= 1'b0;
      I_RD_DATA <= 32'h0000_0000;
      I_RD_DISC <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == `BRF_S_IDLE && nxt_state == `BRF_S_ISSUE) begin
        eng_up_ff <= pick_up;
        T_UP <= pick_up;
        T_ADDR <= c_addr;
        T_CMD <= q_cmd[cand];
        T_PAR <= q_par[cand];
        T_BE_N <= q_pf[cand] ? 4'h0 : q_be[cand];
        T_LEN <= c_len;
        fetched_ff <= 11'h000;
        attempt_ff <= 32'h0000_0000;
        mto_cnt_ff <= 32'h0000_0000;
      end
      if (push)
        fetched_ff <= fetched_ff + 11'h001;
      if (T_REQ & T_RETRY & (fetched_ff == 11'h000))
        attempt_ff <= attempt_ff + 32'h1;
      if (state_ff == `BRF_S_HOLD && !sending_ff)
        mto_cnt_ff <= mto_cnt_ff + 32'h1;
      // Delivery: registered data, disconnect with the last DWORD
      I_RD_VALID <= pop;
      I_RD_DISC <= last_out;
      if (pop)
        I_RD_DATA <= read_data_buffer[rdb_rp_ff];
      if (drop)
        sending_ff <= 1'b0;
      else if (rd_hit)
        sending_ff <= 1'b1;
      else if (last_out | I_RD_END)
        sending_ff <= 1'b0;
      if (drop) begin
        // Leftover prefetched data is thrown away
        rdb_wp_ff <= 5'h00;
        rdb_rp_ff <= 5'h00;
        rdb_cnt_ff <= 6'h00;
      end else begin
        if (push)
          rdb_wp_ff <= rdb_wp_ff + 5'h01;
        if (pop)
          rdb_rp_ff <= rdb_rp_ff + 5'h01;
        rdb_cnt_ff <= rdb_cnt_ff + {5'h00, push} - {5'h00, pop};
      end
    end
  end
endmodule

// ===== brf_forward_checker.sv
// Port-level assertions for the forwarding block
// Bound to brf_forward; single clock, async active-low reset
`timescale 1ns/1ps
module brf_forward_checker (
  // Clock and reset
  input wire MCLK,
  input wire RST_N,
  // Write side
  input wire I_PW_BEAT,
  input wire I_PW_TAKE,
  input wire I_PW_DISC,
  input wire I_WR_START,
  input wire I_WR_FB2B,
  input wire I_WR_RETRY,
  input wire I_DW_REQ,
  input wire I_DW_ACK,
  input wire I_DW_RETRY,
  input wire T_PW_DRAIN,
  input wire T_DW_DONE,
  // Read side
  input wire I_RD_IRDY,
  input wire I_RD_RETRY,
  input wire I_RD_VALID,
  input wire I_RD_DISC,
  input wire T_REQ,
  input wire [31:0] T_ADDR,
  input wire [3:0] T_BE_N,
  input wire [10:0] T_LEN,
  input wire T_LAST,
  input wire T_DVALID
);
  reg [4:0] pw_ff;
  reg [2:0] dw_ff;
  wire [4:0] nxt_pw = pw_ff + {4'h0, I_PW_BEAT & I_PW_TAKE}
    - {4'h0, T_PW_DRAIN & (pw_ff != 5'h00)};
  wire [2:0] nxt_dw = dw_ff + {2'h0, I_DW_ACK}
    - {2'h0, T_DW_DONE & (dw_ff != 3'h0)};
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pw_ff <= 5'h00;
      dw_ff <= 3'h0;
    end else begin
      pw_ff <= nxt_pw;
      dw_ff <= nxt_dw;
    end
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence s_burst;
    T_REQ && T_DVALID && !T_LAST;
  endsequence
  sequence s_last_beat;
    T_REQ && T_DVALID && T_LAST;
  endsequence
  pw_room_a: assert property (I_PW_TAKE == (pw_ff < 5'h10))
    else $error("posted room flag wrong");
  pw_disc_a: assert property (I_PW_BEAT && pw_ff == 5'h0F && !T_PW_DRAIN
    |-> I_PW_DISC)
    else $error("no disconnect on full");
  dw_ack_a: assert property (I_DW_ACK == (I_DW_REQ && dw_ff < 3'h4))
    else $error("delayed write accept wrong");
  fb2b_retry_a: assert property (I_WR_RETRY ==
    (I_WR_START && I_WR_FB2B && pw_ff == 5'h10))
    else $error("second write retry wrong");
  rd_retry_a: assert property (I_RD_RETRY |-> $past(I_RD_IRDY))
    else $error("read retry without request");
  drain_first_a: assert property ($rose(T_REQ) |-> $past(pw_ff) == 5'h00)
    else $error("read issued past posted data");
  pref_lanes_a: assert property (T_REQ && T_LEN > 11'h001
    |-> T_BE_N == 4'h0)
    else $error("burst read lanes not all on");
  one_dword_a: assert property (T_REQ && T_BE_N != 4'h0
    |-> T_LEN == 11'h001)
    else $error("masked read longer than one");
  no_wait_a: assert property (s_burst |=> T_REQ)
    else $error("read stopped before boundary");
  stop_edge_a: assert property (s_last_beat |=> !T_REQ)
    else $error("read ran past boundary");
  fields_held_a: assert property (T_REQ && $past(T_REQ)
    |-> $stable(T_ADDR) && $stable(T_BE_N))
    else $error("read fields moved in flight");
  disc_data_a: assert property (I_RD_DISC |-> I_RD_VALID)
    else $error("disconnect without data");
endmodule
bind brf_forward brf_forward_checker chk (
  .MCLK(MCLK), .RST_N(RST_N), .I_PW_BEAT(I_PW_BEAT),
  .I_PW_TAKE(I_PW_TAKE), .I_PW_DISC(I_PW_DISC), .I_WR_START(I_WR_START),
  .I_WR_FB2B(I_WR_FB2B), .I_WR_RETRY(I_WR_RETRY), .I_DW_REQ(I_DW_REQ),
  .I_DW_ACK(I_DW_ACK), .I_DW_RETRY(I_DW_RETRY), .T_PW_DRAIN(T_PW_DRAIN),
  .T_DW_DONE(T_DW_DONE), .I_RD_IRDY(I_RD_IRDY), .I_RD_RETRY(I_RD_RETRY),
  .I_RD_VALID(I_RD_VALID), .I_RD_DISC(I_RD_DISC), .T_REQ(T_REQ),
  .T_ADDR(T_ADDR), .T_BE_N(T_BE_N), .T_LEN(T_LEN), .T_LAST(T_LAST),
  .T_DVALID(T_DVALID));

// ===== brf_tb.sv
// Self-checking bench for the forwarding block
// APB master, write strobes and reads; target model on far side
`timescale 1ns/1ps
`include "brf_defs.vh"
module tb;
  reg mclk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, e;
  reg pwb = 0, wst = 0, wfb = 0, dwr = 0, drn = 0, dwd = 0;
  reg rs = 0, rup = 0, rpar = 0, ri = 0, iend = 0, cut = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, radr = 0, q;
  reg [3:0] rcmd = 0, rbe = 0, nret = 0;
  integer n_mismatch = 0, n_compared = 0, i;
  wire [31:0] prdata, i_data, t_addr, t_data;
  wire pready, pslverr, take, disc, wret, dack, dret, fup, fdn;
  wire rret, rval, rdisc, t_req, t_up, t_par, t_last;
  wire t_dv, t_rt, t_end, t_ab, serr_n;
  wire [3:0] t_cmd, t_be;
  wire [10:0] t_len;
  always #2.5 mclk = ~mclk;
  brf_forward #(.RETRY_LIMIT(32'h4), .MASTER_TIMEOUT(32'h14)) dut (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .I_PW_BEAT(pwb),
    .I_PW_TAKE(take), .I_PW_DISC(disc), .I_WR_START(wst),
    .I_WR_FB2B(wfb), .I_WR_RETRY(wret), .I_DW_REQ(dwr), .I_DW_ACK(dack),
    .I_DW_RETRY(dret), .T_PW_DRAIN(drn), .T_DW_DONE(dwd),
    .T_FB2B_UP_EN(fup), .T_FB2B_DN_EN(fdn), .I_RD_START(rs),
    .I_RD_UP(rup), .I_RD_CMD(rcmd), .I_RD_ADDR(radr), .I_RD_PAR(rpar),
    .I_RD_IRDY(ri), .I_RD_BE_N(rbe), .I_RD_END(iend),
    .I_RD_RETRY(rret), .I_RD_VALID(rval), .I_RD_DATA(i_data),
    .I_RD_DISC(rdisc), .T_REQ(t_req), .T_UP(t_up), .T_CMD(t_cmd),
    .T_ADDR(t_addr), .T_PAR(t_par), .T_BE_N(t_be), .T_LEN(t_len),
    .T_LAST(t_last), .T_DVALID(t_dv), .T_DATA(t_data), .T_RETRY(t_rt),
    .T_END(t_end), .T_ABORT(t_ab), .PRIMARY_SYSTEM_ERROR_OUT_N(serr_n));
  brf_tgt_model tgt (.clk(mclk), .rst_n(rst_n), .t_req(t_req),
    .t_last(t_last), .t_addr(t_addr), .nret(nret), .t_dvalid(t_dv),
    .t_data(t_data), .t_retry(t_rt), .t_end(t_end), .t_abort(t_ab),
    .cut(cut));
  task chk(input [31:0] s, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (s !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, s, x);
      end
    end
  endtask
  task test_done;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      pen <= 1'h1;
      #1;
      while (pready !== 1'h1) begin
        @(posedge mclk);
        #1;
      end
      // Settled answer; the next edge is the one that takes it
      q = prdata;
      e = pslverr;
      @(posedge mclk);
      psel <= 1'h0;
      pen <= 1'h0;
      #1;
    end
  endtask
  task rreq(input u, input [3:0] c, input [31:0] a, input [3:0] b);
    begin
      @(posedge mclk);
      rs <= 1'h1;
      rup <= u;
      rcmd <= c;
      radr <= a;
      rpar <= ^{a, c};
      rbe <= b;
      @(posedge mclk);
      rs <= 1'h0;
      ri <= 1'h1;
      @(posedge mclk);
      ri <= 1'h0;
      #1;
    end
  endtask
  task waitq(input v);
    begin
      for (i = 0; i < 200 && t_req !== v; i = i + 1) begin
        @(posedge mclk);
        #1;
      end
    end
  endtask
  task rdcase(input u, input [3:0] c, input [31:0] a, input [3:0] b,
      input [31:0] ctl, input [10:0] len, input pf);
    integer k;
    reg [31:0] f;
    begin
      apb(1'h1, `BRF_OFF_CTRL, ctl);
      rreq(u, c, a, b);
      chk(rret, 1'h1);
      waitq(1'h1);
      chk({t_up, t_par, t_cmd, t_be}, {u, ^{a, c}, c, pf ? 4'h0 : b});
      chk(t_addr, a);
      chk(t_len, len);
      waitq(1'h0);
      rreq(u, c, a, b);
      chk(rret, 1'h0);
      k = 0;
      f = 0;
      for (i = 0; i < 80 && rdisc !== 1'h1; i = i + 1) begin
        @(posedge mclk);
        #1;
        if (rval === 1'h1 && k == 0)
          f = i_data;
        if (rval === 1'h1)
          k = k + 1;
      end
      chk(f, a);
      chk(k, len);
    end
  endtask
  task t_regs;
    begin
      apb(1'h0, `BRF_OFF_PFBASE, 32'h0);
      chk(q, `BRF_PFBASE_RST);
      apb(1'h0, `BRF_OFF_RLIM, 32'h0);
      chk(q, 32'h4);
      apb(1'h0, `BRF_OFF_MTO, 32'h0);
      chk(q, 32'h14);
      apb(1'h0, 8'h18, 32'h0);
      chk(e, 1'h1);
      chk(q, 32'h0);
      apb(1'h1, `BRF_OFF_PFBASE, 32'h1000);
      apb(1'h1, `BRF_OFF_PFLIM, 32'h1FFF);
      apb(1'h1, `BRF_OFF_CTRL, 32'h3);
      chk({fup, fdn}, 2'h3);
    end
  endtask
  task t_post;
    begin
      for (i = 0; i < 16; i = i + 1) begin
        @(posedge mclk);
        pwb <= 1'h1;
        #1;
        chk({take, disc}, {1'h1, i == 15});
      end
      @(posedge mclk);
      pwb <= 1'h0;
      wst <= 1'h1;
      wfb <= 1'h1;
      #1;
      chk({take, wret}, 2'h1);
      @(posedge mclk);
      wst <= 1'h0;
      wfb <= 1'h0;
      rreq(1'h0, `BRF_CMD_IOR, 32'h300, 4'h0);
      rreq(1'h0, `BRF_CMD_IOR, 32'h300, 4'h0);
      chk(rret, 1'h1);
      repeat (10) @(posedge mclk);
      #1;
      chk(t_req, 1'h0);
      @(posedge mclk);
      drn <= 1'h1;
      repeat (16) @(posedge mclk);
      drn <= 1'h0;
      waitq(1'h1);
      waitq(1'h0);
      // Read and clear after the 20-cycle master timeout; the duplicate was never queued
      repeat (22) @(posedge mclk);
      apb(1'h0, `BRF_OFF_STAT, 32'h0);
      chk(q, 32'h2);
      apb(1'h1, `BRF_OFF_STAT, 32'h3);
      repeat (60) @(posedge mclk);
      apb(1'h0, `BRF_OFF_STAT, 32'h0);
      chk(q, 32'h0);
    end
  endtask
  task t_dw;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge mclk);
        dwr <= 1'h1;
        #1;
        chk({dack, dret}, i < 4 ? 2'h2 : 2'h1);
      end
      @(posedge mclk);
      dwr <= 1'h0;
      dwd <= 1'h1;
      repeat (4) @(posedge mclk);
      dwd <= 1'h0;
    end
  endtask
  task t_rlim;
    begin
      apb(1'h1, `BRF_OFF_CTRL, 32'h4);
      nret <= 4'hF;
      rreq(1'h0, `BRF_CMD_IOR, 32'h200, 4'h0);
      waitq(1'h1);
      waitq(1'h0);
      repeat (2) @(posedge mclk);
      #1;
      chk(serr_n, 1'h0);
      apb(1'h0, `BRF_OFF_STAT, 32'h0);
      chk(q, 32'h1);
      apb(1'h1, `BRF_OFF_STAT, 32'h1);
      nret <= 4'h2;
    end
  endtask
  task t_cut;
    begin
      apb(1'h1, `BRF_OFF_CTRL, 32'h0);
      cut <= 1'h1;
      rreq(1'h0, `BRF_CMD_MRL, 32'h500, 4'h0);
      waitq(1'h1);
      waitq(1'h0);
      repeat (4) @(posedge mclk);
      #1;
      chk(t_req, 1'h0);
      cut <= 1'h0;
      rreq(1'h0, `BRF_CMD_MRL, 32'h500, 4'h0);
      @(posedge mclk);
      #1;
      chk({rval, rdisc}, 2'h3);
      rreq(1'h0, `BRF_CMD_MRL, 32'h600, 4'h0);
      waitq(1'h1);
      waitq(1'h0);
      rreq(1'h0, `BRF_CMD_MRL, 32'h600, 4'h0);
      @(posedge mclk);
      iend <= 1'h1;
      @(posedge mclk);
      iend <= 1'h0;
      repeat (3) @(posedge mclk);
      #1;
      chk({rval, t_req}, 2'h0);
    end
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    t_regs;
    t_post;
    t_dw;
    t_rlim;
    // Two target retries precede the data here
    rdcase(1'h0, `BRF_CMD_MR, 32'h100, 4'hA, 32'h0, 11'h1, 1'h0);
    nret <= 4'h0;
    rdcase(1'h1, `BRF_CMD_MR, 32'h100, 4'h0, 32'h0, 11'h10, 1'h1);
    rdcase(1'h0, `BRF_CMD_MRL, 32'h108, 4'h0, 32'h400, 11'h2, 1'h1);
    rdcase(1'h0, `BRF_CMD_MRM, 32'h108, 4'h0, 32'h400, 11'h6, 1'h1);
    rdcase(1'h0, `BRF_CMD_MRM, 32'h100, 4'h0, 32'h0, 11'h20, 1'h1);
    rdcase(1'h0, `BRF_CMD_IOR, 32'h100, 4'h5, 32'h0, 11'h1, 1'h0);
    rdcase(1'h0, `BRF_CMD_CFGR, 32'h100, 4'h3, 32'h0, 11'h1, 1'h0);
    rdcase(1'h1, `BRF_CMD_MRL, 32'hFE0, 4'h0, 32'h408, 11'h8, 1'h1);
    rdcase(1'h0, `BRF_CMD_MRL, 32'h100, 4'h0, 32'h1000, 11'h10, 1'h1);
    rdcase(1'h0, `BRF_CMD_MR, 32'h1004, 4'h6, 32'h200, 11'h1, 1'h1);
    t_cut;
    test_done;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    test_done;
  end
endmodule

// ===== brf_tgt_model.sv
// Far-side target answering the block's target reads
// Beat k returns address plus 4k; retries first if asked
`timescale 1ns/1ps
module brf_tgt_model (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Read request from the block
  input wire t_req,
  input wire t_last,
  input wire [31:0] t_addr,
  input wire [3:0] nret,
  input wire cut,
  // Answers
  output reg t_dvalid,
  output wire [31:0] t_data,
  output reg t_retry,
  output reg t_end,
  output wire t_abort
);
  reg [3:0] n_ff;
  reg [10:0] k_ff;
  reg [31:0] fr_ff;
  // Idle data lines move every cycle so stale data cannot match
  assign t_data = t_dvalid ? t_addr + {19'h0, k_ff, 2'h0} : ~fr_ff;
  assign t_abort = 1'h0;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_dvalid <= 1'h0;
      t_retry <= 1'h0;
      t_end <= 1'h0;
      n_ff <= 4'h0;
      k_ff <= 11'h0;
      fr_ff <= 32'h0;
    end else begin
      fr_ff <= fr_ff + 32'h1;
      t_retry <= 1'h0;
      t_end <= 1'h0;
      if (!t_req) begin
        n_ff <= 4'h0;
        k_ff <= 11'h0;
        t_dvalid <= 1'h0;
      end else if (t_dvalid) begin
        k_ff <= k_ff + 11'h1;
        // Cut: disconnect right after the first beat
        if (t_last | cut)
          t_dvalid <= 1'h0;
        t_end <= cut & ~t_last;
      end else if (!t_retry && n_ff < nret) begin
        t_retry <= 1'h1;
        n_ff <= n_ff + 4'h1;
      end else if (!t_retry && k_ff == 11'h0)
        t_dvalid <= 1'h1;
    end
  end
endmodule
